// ==== design/eeprom_cmd_pkg.sv ====
// shared constants for the serial eeprom command port and its host
package eeprom_cmd_pkg;
	// ======================================================
	// frame layout
	localparam int          OPC_W        = 2;
	localparam int          ADDR_W_WORD  = 6;
	localparam int          ADDR_W_BYTE  = 7;
	localparam int          DATA_W_WORD  = 16;
	localparam int          DATA_W_BYTE  = 8;
	localparam int          DEPTH_WORDS  = 64;
	localparam logic [1:0]  OPC_EXT      = 2'h0;
	localparam logic [1:0]  OPC_WRITE    = 2'h1;
	localparam logic [1:0]  OPC_READ     = 2'h2;
	localparam logic [1:0]  OPC_ERASE    = 2'h3;
	localparam logic [1:0]  EXT_LOCK     = 2'h0;
	localparam logic [1:0]  EXT_FILL     = 2'h1;
	localparam logic [1:0]  EXT_CLEAR    = 2'h2;
	localparam logic [1:0]  EXT_UNLOCK   = 2'h3;
	localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
	// ======================================================
	// timing
	localparam int          CLK_HZ              = 50_000_000;
	localparam int          PROGRAM_CYCLE_TIME_US = 10;
	localparam int          PROGRAM_CYCLES      = PROGRAM_CYCLE_TIME_US * (CLK_HZ / 1_000_000);
	localparam int          HOST_SK_HALF        = 4;
endpackage

// ==== design/eeprom_cmd_port.sv ====
// device end: command interpreter, array and self-timed programming
`timescale 1ns/1ps
module eeprom_cmd_port
	import eeprom_cmd_pkg::*;
#(
	parameter int PROGRAM_CYCLES_P = PROGRAM_CYCLES
)
(
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic word_width_select_i,
	eeprom_link_if.device_end link,
	output logic      busy_o,
	output logic      write_enabled_o
);
	// ======================================================
	// state
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_OPC   = 3'b001,
		ST_ADDR  = 3'b010,
		ST_DATA  = 3'b011,
		ST_READ  = 3'b100,
		ST_DONE  = 3'b101
	} phase_e;

	typedef struct packed
	{
		phase_e      phase;
		logic        cs_d;
		logic        sk_d;
		logic [6:0]  cnt;
		logic [1:0]  opc;
		logic [6:0]  addr;
		logic [15:0] data;
		logic [15:0] shifter;
		logic        wen;
		logic        busy;
		logic [31:0] prog_cnt;
		logic        ready_shown;
		logic        dout;
		logic        dout_oe;
		logic        pend_fill;
		logic        pend_wr;
		logic [15:0] pend_data;
		logic [5:0]  pend_addr;
		logic        pend_all;
	} state_s;

	state_s cur;
	state_s next_cur;
	logic [15:0] mem [0:DEPTH_WORDS-1];
	logic        mem_we;
	logic [5:0]  mem_idx;

	function automatic logic [6:0] addr_len(input logic word_width_select);
		addr_len = word_width_select ? 7'(ADDR_W_WORD) : 7'(ADDR_W_BYTE);
	endfunction
	function automatic logic [6:0] data_len(input logic word_width_select);
		data_len = word_width_select ? 7'(DATA_W_WORD) : 7'(DATA_W_BYTE);
	endfunction

	logic sk_rise;
	logic cs_fall;
	logic [5:0] rd_idx;
	assign sk_rise = link.serial_clock_in & ~cur.sk_d;
	assign cs_fall = ~link.chip_select & cur.cs_d;
	// byte mode: lsb of address picks the half of the 16-bit word
	assign rd_idx  = word_width_select_i ? cur.addr[5:0] : cur.addr[6:1];

	// ======================================================
	// next state
	always_comb
	begin
		logic [15:0] word;
		logic [1:0]  ext;
		word = 16'h0;
		ext  = 2'h0;
		next_cur        = cur;
		next_cur.cs_d   = link.chip_select;
		next_cur.sk_d   = link.serial_clock_in;
		mem_we          = 1'b0;
		mem_idx         = cur.pend_addr;
		ext             = word_width_select_i ? cur.addr[5:4] : cur.addr[6:5];
		if (!link.chip_select)
		begin
			next_cur.phase   = ST_IDLE;
			next_cur.dout_oe = 1'b0;
			next_cur.ready_shown = 1'b0;
		end
		else if (cur.busy)
		begin
			next_cur.dout    = 1'b0;
			next_cur.dout_oe = 1'b1;
		end
		if (cur.busy)
		begin
			if (cur.prog_cnt == 32'h0)
			begin
				next_cur.busy = 1'b0;
				next_cur.ready_shown = link.chip_select;
				next_cur.dout = 1'b1;
			end
			else
			begin
				next_cur.prog_cnt = cur.prog_cnt - 32'h1;
				if (cur.pend_wr || cur.pend_all)
				begin
					mem_we = 1'b1;
					next_cur.pend_addr = cur.pend_addr + 6'h1;
					if (!cur.pend_all || cur.pend_addr == 6'(DEPTH_WORDS-1))
					begin
						next_cur.pend_wr  = 1'b0;
						next_cur.pend_all = 1'b0;
					end
				end
			end
		end
		else if (link.chip_select && sk_rise)
		begin
			unique case (cur.phase)
				ST_IDLE:
				begin
					if (link.serial_in)
					begin
						next_cur.phase   = ST_OPC;
						next_cur.cnt     = 7'h0;
						if (cur.ready_shown)
						begin
							next_cur.dout_oe = 1'b0;
							next_cur.ready_shown = 1'b0;
						end
					end
				end
				ST_OPC:
				begin
					next_cur.opc = {cur.opc[0], link.serial_in};
					next_cur.cnt = cur.cnt + 7'h1;
					if (cur.cnt == 7'(OPC_W-1))
					begin
						next_cur.phase = ST_ADDR;
						next_cur.cnt   = 7'h0;
					end
				end
				ST_ADDR:
				begin
					next_cur.addr = {cur.addr[5:0], link.serial_in};
					next_cur.cnt  = cur.cnt + 7'h1;
					if (cur.cnt == addr_len(word_width_select_i) - 7'h1)
					begin
						next_cur.cnt = 7'h0;
						if (cur.opc == OPC_READ)
						begin
							word = mem[word_width_select_i ? next_cur.addr[5:0]
								: next_cur.addr[6:1]];
							if (!word_width_select_i)
								word = next_cur.addr[0] ? {word[15:8], 8'h0}
									: {word[7:0], 8'h0};
							next_cur.shifter = word;
							next_cur.dout    = 1'b0;
							next_cur.dout_oe = 1'b1;
							next_cur.phase   = ST_READ;
						end
						else if (cur.opc == OPC_WRITE || (cur.opc == OPC_EXT
							&& (word_width_select_i ? next_cur.addr[5:4]
							: next_cur.addr[6:5]) == EXT_FILL))
							next_cur.phase = ST_DATA;
						else
							next_cur.phase = ST_DONE;
					end
				end
				ST_DATA:
				begin
					next_cur.data = {cur.data[14:0], link.serial_in};
					next_cur.cnt  = cur.cnt + 7'h1;
					if (cur.cnt == data_len(word_width_select_i) - 7'h1)
						next_cur.phase = ST_DONE;
				end
				ST_READ:
				begin
					// msb first, zeros after last bit
					next_cur.dout    = cur.shifter[15];
					next_cur.shifter = {cur.shifter[14:0], 1'b0};
				end
				default:
				begin
					// a clock after the last bit spoils the frame
					next_cur.phase = ST_IDLE;
				end
			endcase
		end
		if (cs_fall && cur.phase == ST_DONE && !cur.busy)
		begin
			unique case (cur.opc)
				OPC_EXT:
				begin
					if (ext == EXT_UNLOCK)
						next_cur.wen = 1'b1;
					else if (ext == EXT_LOCK)
						next_cur.wen = 1'b0;
					else if (cur.wen)
					begin
						next_cur.pend_all  = 1'b1;
						next_cur.pend_addr = 6'h0;
						next_cur.pend_data = (ext == EXT_FILL) ? (word_width_select_i
							? cur.data : {cur.data[7:0], cur.data[7:0]}) : ERASED_WORD;
						next_cur.busy      = 1'b1;
						next_cur.prog_cnt  = 32'(PROGRAM_CYCLES_P);
					end
				end
				default:
				begin
					if (cur.opc != OPC_READ && cur.wen)
					begin
						word = mem[rd_idx];
						if (cur.opc == OPC_ERASE)
							word = word_width_select_i ? ERASED_WORD
								: (cur.addr[0] ? {8'hFF, word[7:0]} : {word[15:8], 8'hFF});
						else if (word_width_select_i)
							word = cur.data;
						else
							word = cur.addr[0] ? {cur.data[7:0], word[7:0]}
								: {word[15:8], cur.data[7:0]};
						next_cur.pend_data = word;
						next_cur.pend_addr = rd_idx;
						next_cur.pend_wr   = 1'b1;
						next_cur.busy      = 1'b1;
						next_cur.prog_cnt  = 32'(PROGRAM_CYCLES_P);
					end
				end
			endcase
		end
	end

	// ======================================================
	// registers; array holds contents over reset as nonvolatile storage
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			cur <= '0;
		end
		else
		begin
			cur <= next_cur;
		end
		if (mem_we)
			mem[mem_idx] <= cur.pend_data;
	end

	assign link.serial_out    = cur.dout;
	assign link.serial_out_oe = cur.dout_oe;
	assign busy_o             = cur.busy;
	assign write_enabled_o    = cur.wen;
endmodule // eeprom_cmd_port

// ==== design/eeprom_host.sv ====
// host end: frames one command per request and collects read data
`timescale 1ns/1ps
module eeprom_host
	import eeprom_cmd_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        word_width_select_i,
	input  wire logic        req_i,
	input  wire logic [1:0]  opc_i,
	input  wire logic [6:0]  addr_i,
	input  wire logic [15:0] data_i,
	eeprom_link_if.host_end  link,
	output logic             done_o,
	output logic [15:0]      rdata_o,
	output logic             status_o
);
	typedef enum logic [1:0]
	{
		H_IDLE = 2'b00,
		H_SEND = 2'b01,
		H_RECV = 2'b10,
		H_END  = 2'b11
	} hphase_e;

	typedef struct packed
	{
		hphase_e     phase;
		logic        cs;
		logic        sk;
		logic        di;
		logic [2:0]  half;
		logic [5:0]  left;
		logic [33:0] frame;
		logic [4:0]  rleft;
		logic [15:0] rdata;
		logic        done;
		logic        status;
	} hstate_s;

	hstate_s cur;
	hstate_s next_cur;

	always_comb
	begin
		logic [5:0] alen;
		logic [5:0] dlen;
		logic       has_data;
		alen = word_width_select_i ? 6'(ADDR_W_WORD) : 6'(ADDR_W_BYTE);
		dlen = word_width_select_i ? 6'(DATA_W_WORD) : 6'(DATA_W_BYTE);
		has_data = (opc_i == OPC_WRITE) || (opc_i == OPC_EXT && (word_width_select_i
			? addr_i[5:4] : addr_i[6:5]) == EXT_FILL);
		next_cur        = cur;
		next_cur.done   = 1'b0;
		next_cur.status = link.serial_out_oe ? link.serial_out : cur.status;
		unique case (cur.phase)
			H_IDLE:
			begin
				if (req_i)
				begin
					next_cur.frame = {1'b1, opc_i,
						word_width_select_i ? {addr_i[5:0], data_i, 9'h0}
						: {addr_i, data_i[7:0], 16'h0}};
					next_cur.left  = 6'h3 + alen + (has_data ? dlen : 6'h0);
					next_cur.rleft = (opc_i == OPC_READ) ? 5'(dlen) + 5'h1 : 5'h0;
					next_cur.cs    = 1'b1;
					next_cur.half  = 3'h0;
					next_cur.phase = H_SEND;
				end
			end
			H_SEND, H_RECV:
			begin
				next_cur.half = cur.half + 3'h1;
				if (cur.half == 3'(HOST_SK_HALF-1))
				begin
					next_cur.half = 3'h0;
					if (!cur.sk)
					begin
						next_cur.di = cur.frame[33];
						if (cur.phase == H_SEND && cur.left == 6'h0)
						begin
							if (cur.rleft != 5'h0)
								next_cur.phase = H_RECV;
							else
								next_cur.phase = H_END;
						end
						else if (cur.phase == H_RECV)
						begin
							// sampled late in the low phase, nearly a full clock period after launch on the rise
							next_cur.rdata = {cur.rdata[14:0], link.serial_out};
							next_cur.rleft = cur.rleft - 5'h1;
							if (cur.rleft == 5'h1)
								next_cur.phase = H_END;
							else
								next_cur.sk = 1'b1;
						end
						else
							next_cur.sk = 1'b1;
					end
					else
					begin
						next_cur.sk = 1'b0;
						if (cur.phase == H_SEND)
						begin
							next_cur.frame = {cur.frame[32:0], 1'b0};
							next_cur.left  = cur.left - 6'h1;
						end
					end
				end
			end
			H_END:
			begin
				next_cur.cs    = 1'b0;
				next_cur.phase = H_IDLE;
				next_cur.done  = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign link.chip_select     = cur.cs;
	assign link.serial_clock_in = cur.sk;
	assign link.serial_in       = cur.di;
	assign done_o               = cur.done;
	assign rdata_o              = cur.rdata;
	assign status_o             = cur.status;
endmodule // eeprom_host

// ==== design/eeprom_link_if.sv ====
// four-wire serial link between host and eeprom command port
`timescale 1ns/1ps
interface eeprom_link_if;
	logic chip_select;
	logic serial_clock_in;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;

	modport device_end
	(
		input  chip_select,
		input  serial_clock_in,
		input  serial_in,
		output serial_out,
		output serial_out_oe
	);
	modport host_end
	(
		output chip_select,
		output serial_clock_in,
		output serial_in,
		input  serial_out,
		input  serial_out_oe
	);
endinterface

// ==== sim/eeprom_cmd_props.sv ====
// assertions on the serial link between host and eeprom command port
`timescale 1ns/1ps
module eeprom_cmd_props
#(
	parameter int PROGRAM_CYCLES_P = 20
)
(
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic chip_select,
	input  wire logic serial_clock_in,
	input  wire logic serial_out,
	input  wire logic serial_out_oe,
	input  wire logic busy_o,
	input  wire logic write_enabled_o
);
	// ==========================================
	// helper: length of the current busy stretch
	int busy_cnt;

	always_ff @(posedge clk_i)
	begin
		if (srst_i || !busy_o)
			busy_cnt <= 0;
		else
			busy_cnt <= busy_cnt + 1;
	end

	// ==========================================
	// properties
	AST_OE_NEEDS_SELECT: assert property (@(posedge clk_i) disable iff (srst_i)
		serial_out_oe |-> $past(chip_select))
		else $error("output driven while deselected");
	// no disable here: the reset itself is the cause
	AST_LATCH_RESET: assert property (@(posedge clk_i) srst_i |=> !write_enabled_o)
		else $error("write latch survived reset");
	AST_LATCH_SET: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(write_enabled_o) |-> !chip_select && ($past(chip_select) || $past(chip_select, 2)))
		else $error("write latch set away from select fall");
	AST_LATCH_CLR: assert property (@(posedge clk_i) disable iff (srst_i)
		$fell(write_enabled_o) |-> !chip_select && ($past(chip_select) || $past(chip_select, 2)))
		else $error("write latch cleared away from select fall");
	AST_BUSY_START: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(busy_o) |-> !chip_select && ($past(chip_select) || $past(chip_select, 2)))
		else $error("programming began away from select fall");
	AST_BUSY_LOCKED: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(busy_o) |-> $past(write_enabled_o))
		else $error("programming began with latch clear");
	AST_BUSY_LEN: assert property (@(posedge clk_i) disable iff (srst_i)
		$fell(busy_o) |-> busy_cnt >= PROGRAM_CYCLES_P - 1)
		else $error("programming cycle too short");
	AST_BUSY_MAX: assert property (@(posedge clk_i) disable iff (srst_i)
		busy_cnt <= PROGRAM_CYCLES_P + 1)
		else $error("programming cycle too long");
	AST_STATUS_BUSY: assert property (@(posedge clk_i) disable iff (srst_i)
		busy_o && $past(busy_o) && chip_select && $past(chip_select)
		|-> serial_out_oe && !serial_out)
		else $error("busy status not shown");
	// tolerance of one cycle on where the clock rise is seen
	AST_OUT_ON_RISE: assert property (@(posedge clk_i) disable iff (srst_i)
		$changed(serial_out) && serial_out_oe && $past(serial_out_oe) && !busy_o
		&& !$past(busy_o) && !$past(busy_o, 2)
		|-> ($past(serial_clock_in) && !$past(serial_clock_in, 2))
		|| ($past(serial_clock_in, 2) && !$past(serial_clock_in, 3)))
		else $error("output changed without clock rise");
endmodule // eeprom_cmd_props

// ==== sim/tb_serial_eeprom_command_port.sv ====
// testbench: host and eeprom command port joined over the serial link
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("Error at %0t: got %h expected %h", $time, got, exp); \
		end \
	end
module tb_serial_eeprom_command_port
	import eeprom_cmd_pkg::*;
;
	// ==========================================
	// signals
	// short program cycle, yet long enough for a 64-word fill and a frame sent while busy
	localparam int PROG_P = 200;
	typedef struct packed
	{
		logic [1:0]  opc;
		logic [6:0]  addr;
		logic [15:0] data;
		logic        rd;
		logic [15:0] exp;
		logic        wen;
	} row_s;

	logic        clk_i           = 1'b0;
	logic        srst_i          = 1'b1;
	logic        req_i           = 1'b0;
	logic [1:0]  opc_i           = 2'h0;
	logic [6:0]  addr_i          = 7'h00;
	logic [15:0] data_i          = 16'h0000;
	logic        word_width_select_i = 1'b1;
	logic        done_o;
	logic        status_o;
	logic [15:0] rdata_o;
	logic        busy_o;
	logic        write_enabled_o;
	int          error_cnt       = 0;
	int          cmp_count       = 0;
	// word mode: extended code sits in addr[5:4]
	row_s        rows [15]       = '{
		'{OPC_EXT, 7'h30, 16'h0000, 1'b0, 16'h0000, 1'b1},
		'{OPC_WRITE, 7'h05, 16'hA5C3, 1'b0, 16'h0000, 1'b1},
		'{OPC_READ, 7'h05, 16'h0000, 1'b1, 16'hA5C3, 1'b1},
		'{OPC_WRITE, 7'h3F, 16'h8001, 1'b0, 16'h0000, 1'b1},
		'{OPC_READ, 7'h3F, 16'h0000, 1'b1, 16'h8001, 1'b1},
		'{OPC_ERASE, 7'h05, 16'h0000, 1'b0, 16'h0000, 1'b1},
		'{OPC_READ, 7'h05, 16'h0000, 1'b1, ERASED_WORD, 1'b1},
		'{OPC_READ, 7'h3F, 16'h0000, 1'b1, 16'h8001, 1'b1},
		'{OPC_EXT, 7'h10, 16'h5A5A, 1'b0, 16'h0000, 1'b1},
		'{OPC_READ, 7'h00, 16'h0000, 1'b1, 16'h5A5A, 1'b1},
		'{OPC_EXT, 7'h20, 16'h0000, 1'b0, 16'h0000, 1'b1},
		'{OPC_READ, 7'h3F, 16'h0000, 1'b1, ERASED_WORD, 1'b1},
		'{OPC_EXT, 7'h00, 16'h0000, 1'b0, 16'h0000, 1'b0},
		'{OPC_WRITE, 7'h3F, 16'h1234, 1'b0, 16'h0000, 1'b0},
		'{OPC_READ, 7'h3F, 16'h0000, 1'b1, ERASED_WORD, 1'b0}
	};

	eeprom_link_if link ();

	eeprom_cmd_port #(.PROGRAM_CYCLES_P(PROG_P)) i_eeprom_cmd_port (.clk_i(clk_i),
		.srst_i(srst_i), .word_width_select_i(word_width_select_i), .link(link),
		.busy_o(busy_o), .write_enabled_o(write_enabled_o));
	eeprom_host i_eeprom_host (.clk_i(clk_i), .srst_i(srst_i),
		.word_width_select_i(word_width_select_i),
		.req_i(req_i), .opc_i(opc_i), .addr_i(addr_i), .data_i(data_i), .link(link),
		.done_o(done_o), .rdata_o(rdata_o), .status_o(status_o));
	eeprom_cmd_props #(.PROGRAM_CYCLES_P(PROG_P)) i_eeprom_cmd_props (.clk_i(clk_i),
		.srst_i(srst_i), .chip_select(link.chip_select),
		.serial_clock_in(link.serial_clock_in), .serial_out(link.serial_out),
		.serial_out_oe(link.serial_out_oe), .busy_o(busy_o),
		.write_enabled_o(write_enabled_o));

	// ==========================================
	// tasks
	task automatic report_and_stop();
		if (error_cnt == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// bounded wait: done pulse (sel 0) or busy low (sel 1)
	task automatic wait_for(input logic sel);
		int n;
		n = 0;
		while ((sel ? busy_o !== 1'b0 : done_o !== 1'b1))
		begin
			@(negedge clk_i);
			n++;
			if (n > 3000)
			begin
				error_cnt++;
				$display("Error at %0t: wait timed out", $time);
				report_and_stop();
			end
		end
	endtask

	// frame one command and wait for its done pulse; returns on a falling edge
	task automatic start_cmd(input row_s r);
		@(posedge clk_i);
		opc_i  <= r.opc;
		addr_i <= r.addr;
		data_i <= r.data;
		req_i  <= 1'b1;
		@(posedge clk_i);
		req_i  <= 1'b0;
		wait_for(1'b0);
	endtask

	// one command; next one only once programming is over
	task automatic run_cmd(input row_s r);
		start_cmd(r);
		repeat (3) @(negedge clk_i);
		wait_for(1'b1);
	endtask

	// ==========================================
	// clock and main sequence
	initial
	begin
		forever #10 clk_i = ~clk_i;
	end

	initial
	begin
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		@(negedge clk_i);
		`CHK(write_enabled_o, 1'b0)
		foreach (rows[i])
		begin
			run_cmd(rows[i]);
			if (rows[i].rd)
				`CHK(rdata_o, rows[i].exp)
			`CHK(write_enabled_o, rows[i].wen)
		end
		// a lock sent during programming is ignored; select shows busy meanwhile
		run_cmd(rows[0]);
		start_cmd(rows[13]);
		start_cmd(rows[12]);
		`CHK(status_o, 1'b0)
		`CHK(write_enabled_o, 1'b1)
		wait_for(1'b1);
		run_cmd(rows[14]);
		`CHK(rdata_o, 16'h1234)
		// reset in mid-run drops an enabled latch, array keeps its data
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		@(negedge clk_i);
		`CHK(write_enabled_o, 1'b0)
		run_cmd(rows[14]);
		`CHK(rdata_o, 16'h1234)
		// byte mode: address lsb picks the half, dummy zero lands in bit 8
		@(posedge clk_i);
		word_width_select_i <= 1'b0;
		run_cmd('{OPC_EXT, 7'h60, 16'h0000, 1'b0, 16'h0000, 1'b1});
		run_cmd('{OPC_WRITE, 7'h7E, 16'h00AB, 1'b0, 16'h0000, 1'b1});
		run_cmd('{OPC_READ, 7'h7E, 16'h0000, 1'b1, 16'h0000, 1'b1});
		`CHK(rdata_o[7:0], 8'hAB)
		run_cmd('{OPC_READ, 7'h7F, 16'h0000, 1'b1, 16'h0000, 1'b1});
		`CHK(rdata_o[8:0], 9'h012)
		report_and_stop();
	end
endmodule // tb_serial_eeprom_command_port
